// File: pkg/boot_loader_pkg.sv
// constants and types shared by the boot mode serial ram loader
package boot_loader_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BIT_CYCLES = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int HOLD_MACHINE_CYCLES = 30;
  localparam int SETTLE_SHORT_CYCLES = 16;
  localparam int SETTLE_LONG_CYCLES = 4064;
  localparam logic [15:0] LOAD_BASE_ADDR = 16'h0050;
  localparam logic [15:0] PROG_START_ADDR = 16'h0051;
  localparam logic [7:0] JUMP_KEY = 8'hcc;
  localparam logic SECURITY_OPEN = 1'b1;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_RAM_LOADER,
    MODE_JUMP,
    MODE_NONE
  } boot_mode_t;

  function automatic boot_mode_t decode_mode(input logic irq_high, input logic cap, input logic sa, input logic sb);
    if (!irq_high || !cap) begin
      decode_mode = MODE_SINGLE_CHIP;
    end else if (sa && !sb) begin
      decode_mode = MODE_RAM_LOADER;
    end else if (sa && sb) begin
      decode_mode = MODE_JUMP;
    end else begin
      decode_mode = MODE_SINGLE_CHIP;
    end
  endfunction : decode_mode
endpackage : boot_loader_pkg

// File: rtl/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  assign in_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_q != rd_q;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_q[rd_q[AW-1:0]];

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage has no reset, which keeps it a plain ram array
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end
endmodule : byte_fifo

// File: rtl/boot_mode_serial_ram_loader.sv
// boot mode decode, oscillator settle wait and serial ram loader
`timescale 1ns/1ps
module boot_mode_serial_ram_loader
  import boot_loader_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_LONG_CYCLES,
  parameter int BIT_TIME = BIT_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic power_on_in,
  input wire logic irq_high_volt_in,
  input wire logic capture_one_pin_in,
  input wire logic boot_select_a_in,
  input wire logic boot_select_b_in,
  input wire logic security_lock_bit_in,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  input wire logic serial_rx_in,
  input wire logic ram_ready_in,
  output logic ram_we_out,
  output logic [15:0] ram_addr_out,
  output logic [7:0] ram_data_out,
  output logic [1:0] boot_mode_out,
  output logic cpu_run_out,
  output logic [15:0] start_addr_out,
  output logic loader_busy_out
);
  import boot_loader_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] s1_q, s2_q;
  logic [23:0] p1_q, p2_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // resetting high makes an external reset wait until the real pin levels have crossed
      s1_q <= 7'h7f;
      s2_q <= 7'h7f;
      p1_q <= '0;
      p2_q <= '0;
    end else begin
      s1_q <= {serial_rx_in, irq_high_volt_in, capture_one_pin_in, boot_select_a_in, boot_select_b_in,
               security_lock_bit_in, power_on_in};
      s2_q <= s1_q;
      p1_q <= {port_a_in, port_b_in, port_c_in};
      p2_q <= p1_q;
    end
  end
  logic rx, irq_s, cap_s, sa_s, sb_s, sec_s, pwr_s;
  assign {rx, irq_s, cap_s, sa_s, sb_s, sec_s, pwr_s} = s2_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_SETTLE, ST_SAMPLE, ST_LOAD, ST_JUMP, ST_RUN, ST_HALT} seq_t;
  localparam int SW = $clog2(SETTLE_CYCLES + 4);
  seq_t st_q, st_d;
  logic [SW-1:0] cnt_q, cnt_d;
  boot_mode_t mode_q, mode_d;
  logic [15:0] start_q, start_d;
  logic [7:0] total_q, total_d;
  logic [7:0] stored_q, stored_d;
  logic [15:0] waddr_q, waddr_d;
  logic fifo_valid, fifo_ready, fifo_in_ready;
  logic [7:0] fifo_data;
  logic byte_done;
  logic [7:0] byte_val;

  // after an external reset only the pins need to settle; power-on waits the full delay
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    start_d = start_q;
    total_d = total_q;
    stored_d = stored_q;
    waddr_d = waddr_q;
    case (st_q)
      ST_SETTLE: begin
        if (cnt_q >= SW'(SETTLE_CYCLES - 1) || !pwr_s) begin
          st_d = ST_SAMPLE;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_SAMPLE: begin
        // pins are read once the synchronisers hold post-release levels; the fixture keeps them steady
        mode_d = decode_mode(irq_s, cap_s, sa_s, sb_s);
        if (mode_d == MODE_RAM_LOADER && sec_s == SECURITY_OPEN) begin
          st_d = ST_LOAD;
          waddr_d = LOAD_BASE_ADDR;
          stored_d = '0;
          total_d = '0;
        end else if (mode_d == MODE_JUMP && p2_q[23:16] == JUMP_KEY) begin
          st_d = ST_RUN;
          start_d = p2_q[15:0];
        end else if (mode_d == MODE_JUMP) begin
          st_d = ST_HALT;
        end else begin
          mode_d = MODE_SINGLE_CHIP;
          st_d = ST_RUN;
          start_d = '0;
        end
      end
      ST_LOAD: begin
        if (fifo_valid && ram_ready_in) begin
          waddr_d = waddr_q + 16'h0001;
          stored_d = stored_q + 8'h01;
          if (stored_q == 8'h00) begin
            total_d = fifo_data;
          end
          if ((stored_q == 8'h00 && fifo_data <= 8'h01) || (stored_q != 8'h00 && stored_q + 8'h01 == total_q)) begin
            st_d = ST_RUN;
            start_d = PROG_START_ADDR;
          end
        end
      end
      ST_RUN, ST_HALT: begin
        st_d = st_q;
      end
      default: begin
        st_d = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= ST_SETTLE;
      cnt_q <= '0;
      mode_q <= MODE_SINGLE_CHIP;
      start_q <= '0;
      total_q <= '0;
      stored_q <= '0;
      waddr_q <= LOAD_BASE_ADDR;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      start_q <= start_d;
      total_q <= total_d;
      stored_q <= stored_d;
      waddr_q <= waddr_d;
    end
  end

  // ram is never cleared here, so a held-off program survives reset
  assign fifo_ready = (st_q == ST_LOAD) && ram_ready_in;
  assign ram_we_out = fifo_ready && fifo_valid;
  assign ram_addr_out = waddr_q;
  assign ram_data_out = fifo_data;
  assign boot_mode_out = mode_q;
  assign cpu_run_out = st_q == ST_RUN;
  assign start_addr_out = start_q;
  assign loader_busy_out = st_q == ST_LOAD;

  // ----------------------------------------------------------------
  // serial receiver
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_t;
  localparam int BW = $clog2(BIT_TIME + 1);
  rx_t rs_q, rs_d;
  logic [BW-1:0] bt_q, bt_d;
  logic [2:0] bi_q, bi_d;
  logic [7:0] sh_q, sh_d;
  logic rx_en;
  assign rx_en = st_q == ST_LOAD;

  // a byte is lost if the ram side stalls the fifo full; host pacing avoids it
  always_comb begin
    rs_d = rs_q;
    bt_d = bt_q;
    bi_d = bi_q;
    sh_d = sh_q;
    byte_done = 1'b0;
    byte_val = sh_q;
    case (rs_q)
      RX_IDLE: begin
        bt_d = '0;
        if (rx_en && !rx) begin
          rs_d = RX_START;
        end
      end
      RX_START: begin
        bt_d = bt_q + 1'b1;
        if (bt_q == BW'(BIT_TIME / 2)) begin
          bt_d = '0;
          rs_d = rx ? RX_IDLE : RX_DATA;
          bi_d = '0;
        end
      end
      RX_DATA: begin
        bt_d = bt_q + 1'b1;
        if (bt_q == BW'(BIT_TIME - 1)) begin
          bt_d = '0;
          sh_d = {rx, sh_q[7:1]};
          bi_d = bi_q + 3'h1;
          if (bi_q == 3'h7) begin
            rs_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        bt_d = bt_q + 1'b1;
        if (bt_q == BW'(BIT_TIME - 1)) begin
          rs_d = RX_IDLE;
          byte_done = rx;
        end
      end
      default: begin
        rs_d = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rs_q <= RX_IDLE;
      bt_q <= '0;
      bi_q <= '0;
      sh_q <= '0;
    end else begin
      rs_q <= rs_d;
      bt_q <= bt_d;
      bi_q <= bi_d;
      sh_q <= sh_d;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(byte_done),
    .in_ready_out(fifo_in_ready),
    .in_data_in(byte_val),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_ready),
    .out_data_out(fifo_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence load_entry_s;
    st_q == ST_SAMPLE && decode_mode(irq_s, cap_s, sa_s, sb_s) == MODE_RAM_LOADER && sec_s;
  endsequence
  AST_LOADER_ENTRY: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    load_entry_s |=> st_q == ST_LOAD && waddr_q == LOAD_BASE_ADDR) else $error("loader not entered");
  AST_SEC_LOCK: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_SAMPLE && !sec_s) |=> st_q != ST_LOAD) else $error("loader entered while locked");
  AST_SINGLE: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_SAMPLE && !irq_s) |=> st_q == ST_RUN && mode_q == MODE_SINGLE_CHIP) else $error("single chip");
  AST_JUMP: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_SAMPLE && irq_s && cap_s && sa_s && sb_s && p2_q[23:16] == JUMP_KEY)
    |=> cpu_run_out && start_addr_out == $past(p2_q[15:0])) else $error("jump target");
  AST_ADDR_STEP: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    ram_we_out |=> ram_addr_out == $past(ram_addr_out) + 16'h0001) else $error("address step");
  AST_RUN_START: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    ($rose(cpu_run_out) && mode_q == MODE_RAM_LOADER) |-> start_addr_out == PROG_START_ADDR) else $error("start");
  AST_HOLD: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (loader_busy_out && !fifo_valid) |=> !cpu_run_out) else $error("ran without data");
  AST_STOP_BIT: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    byte_done |-> rs_q == RX_STOP && bi_q == 3'h0 && rx) else $error("byte without stop bit");
  AST_SETTLE: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_SETTLE && pwr_s && cnt_q < SW'(SETTLE_CYCLES - 1)) |=> st_q == ST_SETTLE)
    else $error("settle too short");
endmodule : boot_mode_serial_ram_loader

// File: testbench/serial_host_model.sv
// serial host model that frames bytes onto the loader's receive line
`timescale 1ns/1ps
module serial_host_model #(
  parameter int BIT_TIME = 8
) (
  input wire logic sys_clk_in,
  output logic serial_rx_out
);
  initial serial_rx_out = 1'b1;
  // a broken stop bit is sent only when a test asks for one
  task automatic send_byte(input logic [7:0] data, input logic stop_ok);
    logic [9:0] frame;
    frame = {stop_ok, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_in);
      #1 serial_rx_out = frame[i];
      repeat (BIT_TIME - 1) @(posedge sys_clk_in);
    end
    @(posedge sys_clk_in);
    // idle gap lets the receiver resync after a broken frame
    #1 serial_rx_out = 1'b1;
    repeat (2 * BIT_TIME) @(posedge sys_clk_in);
  endtask : send_byte
endmodule : serial_host_model

// File: testbench/boot_mode_serial_ram_loader_bench.sv
// self-checking bench for the boot mode serial ram loader
`timescale 1ns/1ps
module boot_mode_serial_ram_loader_bench;
  import boot_loader_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, power_on = 1'b1, irq_high = 1'b0, cap = 1'b0, sa = 1'b0, sb = 1'b0, sec = 1'b1;
  logic [7:0] pa = 8'h00, pb = 8'h00, pc = 8'h00;
  logic rx, ram_ready = 1'b1, ram_we, run, busy;
  logic [15:0] ram_addr, start_addr;
  logic [7:0] ram_data;
  logic [1:0] mode;
  logic [15:0] wr_addr[$];
  logic [7:0] wr_data[$];
  int miscompares = 0, compares = 0, cyc = 0;
  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  initial forever #50 clk = ~clk;
  serial_host_model #(.BIT_TIME(8)) host (.sys_clk_in(clk), .serial_rx_out(rx));
  boot_mode_serial_ram_loader #(.SETTLE_CYCLES(16), .BIT_TIME(8)) DUT (
    .sys_clk_in(clk), .resetn_in(resetn), .power_on_in(power_on), .irq_high_volt_in(irq_high),
    .capture_one_pin_in(cap), .boot_select_a_in(sa), .boot_select_b_in(sb), .security_lock_bit_in(sec),
    .port_a_in(pa), .port_b_in(pb), .port_c_in(pc), .serial_rx_in(rx), .ram_ready_in(ram_ready),
    .ram_we_out(ram_we), .ram_addr_out(ram_addr), .ram_data_out(ram_data), .boot_mode_out(mode),
    .cpu_run_out(run), .start_addr_out(start_addr), .loader_busy_out(busy));
  // ram stalls three cycles in eight so the fifo has to hold bytes back
  always @(posedge clk) begin
    if (ram_we === 1'b1 && ram_ready === 1'b1) begin
      wr_addr.push_back(ram_addr);
      wr_data.push_back(ram_data);
    end
    #1 ram_ready = (cyc % 8) > 2;
    cyc++;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // pins stay put long after release, well past the fixture hold time
  task automatic boot(input logic i, input logic c, input logic a, input logic b, input logic s);
    @(posedge clk);
    #1 resetn = 1'b0;
    {irq_high, cap, sa, sb, sec} = {i, c, a, b, s};
    wr_addr.delete();
    wr_data.delete();
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
  endtask : boot
  task automatic wait_run(input int n);
    for (int k = 0; k < n && run !== 1'b1; k++) @(posedge clk);
    #1;
  endtask : wait_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_single_chip();
    boot(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    repeat (15) @(posedge clk);
    #1 check("run during settle", 16'(run), 16'h0000);
    wait_run(40);
    check("single run", 16'(run), 16'h0001);
    check("single mode", 16'(mode), 16'(MODE_SINGLE_CHIP));
    check("single start", start_addr, 16'h0000);
    check("ram kept", 16'(wr_addr.size()), 16'h0000);
    boot(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    wait_run(40);
    check("select a low mode", 16'(mode), 16'(MODE_SINGLE_CHIP));
    $display("test single chip done");
  endtask : test_single_chip
  task automatic test_jump();
    pa = JUMP_KEY;
    pb = 8'h12;
    pc = 8'h34;
    boot(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    wait_run(60);
    check("jump run", 16'(run), 16'h0001);
    check("jump mode", 16'(mode), 16'(MODE_JUMP));
    check("jump start", start_addr, 16'h1234);
    pa = 8'hcd;
    boot(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (60) @(posedge clk);
    #1 check("bad key run", 16'(run), 16'h0000);
    $display("test jump done");
  endtask : test_jump
  task automatic test_loader();
    logic [7:0] exp[4];
    exp = '{8'h04, 8'ha1, 8'hb2, 8'hc3};
    boot(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    #1 check("loader mode", 16'(mode), 16'(MODE_RAM_LOADER));
    check("loader busy", 16'(busy), 16'h0001);
    // count is three program bytes plus the count byte itself
    host.send_byte(exp[0], 1'b1);
    host.send_byte(8'h5a, 1'b0);
    for (int k = 1; k < 4; k++) host.send_byte(exp[k], 1'b1);
    wait_run(60);
    check("loader run", 16'(run), 16'h0001);
    check("loader start", start_addr, PROG_START_ADDR);
    check("write count", 16'(wr_addr.size()), 16'h0004);
    for (int k = 0; k < 4 && k < wr_addr.size(); k++) begin
      check("write addr", wr_addr[k], LOAD_BASE_ADDR + 16'(k));
      check("write data", 16'(wr_data[k]), 16'(exp[k]));
    end
    $display("test loader done");
  endtask : test_loader
  task automatic test_hold_off();
    boot(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    host.send_byte(8'h05, 1'b1);
    host.send_byte(8'h11, 1'b1);
    host.send_byte(8'h22, 1'b1);
    repeat (100) @(posedge clk);
    #1 check("hold run", 16'(run), 16'h0000);
    check("hold busy", 16'(busy), 16'h0001);
    check("hold writes", 16'(wr_addr.size()), 16'h0003);
    $display("test hold off done");
  endtask : test_hold_off
  task automatic test_secured();
    boot(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    repeat (40) @(posedge clk);
    host.send_byte(8'h02, 1'b1);
    repeat (40) @(posedge clk);
    #1 check("secured busy", 16'(busy), 16'h0000);
    check("secured writes", 16'(wr_addr.size()), 16'h0000);
    $display("test secured done");
  endtask : test_secured
  // an external reset skips the settle wait and only waits for the pins to cross the synchronisers
  task automatic test_external_reset();
    power_on = 1'b0;
    boot(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge clk);
    #1 check("ext reset mode", 16'(mode), 16'(MODE_RAM_LOADER));
    check("ext reset busy", 16'(busy), 16'h0001);
    check("ext reset run", 16'(run), 16'h0000);
    power_on = 1'b1;
    $display("test external reset done");
  endtask : test_external_reset
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    test_jump();
    test_loader();
    test_hold_off();
    test_single_chip();
    test_secured();
    test_external_reset();
    end_of_test();
  end
  // the tests need about 1350 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule : boot_mode_serial_ram_loader_bench
